// [caf_pkg.sv]
// Purpose: Shared constants and types of the counter array control and flag block.
// Assumes: AHB-Lite register bus with 32-bit data and byte addresses.
// Notes:   Every register takes one aligned word; unused bits read as zero.
package caf_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          CAF_ADDR_W       = 8;
    localparam logic [7:0]  CAF_CTRL_OFF     = 8'h00;
    localparam logic [7:0]  CAF_MODE_OFF     = 8'h04;
    localparam logic [7:0]  CAF_MODIE_OFF    = 8'h08;
    localparam logic [7:0]  CAF_COUNT_OFF    = 8'h0C;
    localparam logic [7:0]  CAF_ISTAT_OFF    = 8'h10;
    localparam logic [7:0]  CAF_IMASK_OFF    = 8'h14;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int          CAF_MOD_N        = 6;
    localparam int          CAF_CNT_W        = 16;
    localparam int          CAF_OVF_BIT      = 7;
    localparam int          CAF_RUN_BIT      = 6;
    localparam int          CAF_OVF_EN_BIT   = 0;
    localparam int          CAF_EVT_N        = CAF_MOD_N + 1;
    localparam logic [6:0]  CAF_FLAGS_RST    = 7'h00;
    localparam logic [5:0]  CAF_MODIE_RST    = 6'h00;
    localparam logic [6:0]  CAF_IMASK_RST    = 7'h00;
    localparam logic [1:0]  CAF_HTRANS_NSEQ  = 2'h2;

    // ------------------------------------------------------------------
    // Captured address phase
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CAF_ADDR_W-1:0] addr;
        logic                  write;
        logic                  valid;
    } caf_aphase_s;

endpackage : caf_pkg

// [caf_counter.sv]
// Purpose: Free running array counter with run control and a wrap pulse.
// Assumes: tick is a one-cycle enable pulse giving the counter's timebase.
// Notes:   wrapPulse is high for the one cycle after the count passes max to zero.
`timescale 1ns/1ps
module caf_counter
    import caf_pkg::*;
#(
    parameter int WIDTH = CAF_CNT_W
)
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Control
    input  wire logic             run,
    input  wire logic             tick,
    // Status
    output logic [WIDTH-1:0]      count,
    output logic                  wrapPulse
);

    logic [WIDTH-1:0] next_count;
    logic             next_wrapPulse;

    always_comb
    begin
        next_count     = count;
        next_wrapPulse = 1'b0;
        if (run && tick)
        begin
            next_count     = count + 1'b1;
            next_wrapPulse = &count;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            count     <= '0;
            wrapPulse <= 1'b0;
        end
        else
        begin
            count     <= next_count;
            wrapPulse <= next_wrapPulse;
        end
    end

endmodule : caf_counter

// [caf_flag_bank.sv]
// Purpose: Bank of sticky flags set by hardware and written by software.
// Assumes: setPulse bits are one-cycle events; wrEn is one cycle per write.
// Notes:   A set in the cycle of a write always wins over the write.
`timescale 1ns/1ps
module caf_flag_bank
    import caf_pkg::*;
#(
    parameter int         WIDTH   = CAF_EVT_N,
    parameter bit         CLR_W1C = 1'b0
)
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Hardware events
    input  wire logic [WIDTH-1:0] setPulse,
    // Software write
    input  wire logic             wrEn,
    input  wire logic [WIDTH-1:0] wrData,
    // Flags
    output logic [WIDTH-1:0]      flags
);

    logic [WIDTH-1:0] next_flags;

    // Load mode takes the written value; clear mode drops bits written with one.
    always_comb
    begin
        next_flags = flags;
        if (wrEn)
        begin
            next_flags = CLR_W1C ? (flags & ~wrData) : wrData;
        end
        next_flags = next_flags | setPulse;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            flags <= '0;
        end
        else
        begin
            flags <= next_flags;
        end
    end

endmodule : caf_flag_bank

// [caf_control_flags.sv]
// Purpose: Control and status byte of a six-module counter array, on AHB-Lite.
// Assumes: Module match or capture events arrive as one-cycle pulses.
// Notes:   Zero wait state slave; every response is OKAY.
//
// Notes on behaviour
// - Counter overflow flag, control bit 7, sets when counter wraps max to zero.
// - Enabled and set overflow flag raises the overflow interrupt request.
// - Overflow flag is never cleared by hardware; software clears it.
// - Run bit, control bit 6: one runs the counter, zero holds it.
// - Bits 5..0 are module event flags, set on that module's match or capture.
// - Enabled and set module flag raises the shared module event request.
// - Module flags stay set until software clears them; servicing clears nothing.
// - Overflow request masked by overflow enable, mode register bit 0.
// - Each module request masked by its own enable bit.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module caf_control_flags
    import caf_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Array events
    input  wire logic                 countTick,
    input  wire logic [CAF_MOD_N-1:0] moduleEvent,
    // Requests and status
    output logic                      counterRun,
    output logic                      overflowIrq,
    output logic                      moduleIrq,
    output logic                      irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    caf_aphase_s             aph;
    caf_aphase_s             next_aph;
    logic [31:0]             next_hrdata;
    logic                    next_counterRun;
    logic                    overflowIrqEnable;
    logic                    next_overflowIrqEnable;
    logic [CAF_MOD_N-1:0]    moduleIrqEnable;
    logic [CAF_MOD_N-1:0]    next_moduleIrqEnable;
    logic [CAF_EVT_N-1:0]    intMask;
    logic [CAF_EVT_N-1:0]    next_intMask;
    logic                    next_overflowIrq;
    logic                    next_moduleIrq;
    logic                    next_irq;
    logic [CAF_CNT_W-1:0]    count;
    logic                    wrapPulse;
    logic [CAF_EVT_N-1:0]    ctrlFlags;
    logic [CAF_EVT_N-1:0]    intStatus;
    logic [CAF_EVT_N-1:0]    eventSet;
    logic                    wrCtrl;
    logic                    wrIstat;
    logic                    counterOverflowFlag;
    logic [CAF_MOD_N-1:0]    moduleEventFlag;

    assign counterOverflowFlag = ctrlFlags[CAF_EVT_N-1];
    assign moduleEventFlag     = ctrlFlags[CAF_MOD_N-1:0];
    // Overflow is the top event bit, above the six module events.
    assign eventSet            = {wrapPulse, moduleEvent};

    function automatic logic wr_hit(caf_aphase_s a, logic [7:0] off);
        return a.valid && a.write && (a.addr == off);
    endfunction : wr_hit

    assign wrCtrl  = wr_hit(aph, CAF_CTRL_OFF);
    assign wrIstat = wr_hit(aph, CAF_ISTAT_OFF);

    // ------------------------------------------------------------------
    // Counter and flag banks
    // ------------------------------------------------------------------
    caf_counter #(
        .WIDTH     (CAF_CNT_W)
    ) u_counter (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .run       (counterRun),
        .tick      (countTick),
        .count     (count),
        .wrapPulse (wrapPulse)
    );

    // Control byte flags load the written value, hardware sets win.
    caf_flag_bank #(
        .WIDTH    (CAF_EVT_N),
        .CLR_W1C  (1'b0)
    ) u_ctrl_flags (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .setPulse (eventSet),
        .wrEn     (wrCtrl),
        .wrData   ({hwdata[CAF_OVF_BIT], hwdata[CAF_MOD_N-1:0]}),
        .flags    (ctrlFlags)
    );

    // Interrupt status is write-one-to-clear.
    caf_flag_bank #(
        .WIDTH    (CAF_EVT_N),
        .CLR_W1C  (1'b1)
    ) u_int_status (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .setPulse (eventSet),
        .wrEn     (wrIstat),
        .wrData   (hwdata[CAF_EVT_N-1:0]),
        .flags    (intStatus)
    );

    // ------------------------------------------------------------------
    // Bus and register logic
    // ------------------------------------------------------------------
    always_comb
    begin
        next_aph.valid  = hsel && hready && (htrans == CAF_HTRANS_NSEQ);
        next_aph.write  = hwrite;
        next_aph.addr   = haddr[CAF_ADDR_W-1:0];
        next_hrdata     = 32'h0000_0000;
        // Read data are taken in the address phase, so a read straight after a write
        // to the same register still returns the old value.
        if (next_aph.valid && !hwrite)
        begin
            unique case (haddr[CAF_ADDR_W-1:0])
                CAF_CTRL_OFF:  next_hrdata = {24'h00_0000, counterOverflowFlag,
                                              counterRun, moduleEventFlag};
                CAF_MODE_OFF:  next_hrdata = {31'h0000_0000, overflowIrqEnable};
                CAF_MODIE_OFF: next_hrdata = {26'h000_0000, moduleIrqEnable};
                CAF_COUNT_OFF: next_hrdata = {16'h0000, count};
                CAF_ISTAT_OFF: next_hrdata = {25'h000_0000, intStatus};
                CAF_IMASK_OFF: next_hrdata = {25'h000_0000, intMask};
                default:       next_hrdata = 32'h0000_0000;
            endcase
        end
        next_counterRun        = counterRun;
        next_overflowIrqEnable = overflowIrqEnable;
        next_moduleIrqEnable   = moduleIrqEnable;
        next_intMask           = intMask;
        if (wrCtrl)
        begin
            next_counterRun = hwdata[CAF_RUN_BIT];
        end
        if (wr_hit(aph, CAF_MODE_OFF))
        begin
            next_overflowIrqEnable = hwdata[CAF_OVF_EN_BIT];
        end
        if (wr_hit(aph, CAF_MODIE_OFF))
        begin
            next_moduleIrqEnable = hwdata[CAF_MOD_N-1:0];
        end
        if (wr_hit(aph, CAF_IMASK_OFF))
        begin
            next_intMask = hwdata[CAF_EVT_N-1:0];
        end
        next_overflowIrq = counterOverflowFlag && overflowIrqEnable;
        next_moduleIrq   = |(moduleEventFlag & moduleIrqEnable);
        next_irq         = |(intStatus & intMask);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            aph               <= '0;
            hrdata            <= 32'h0000_0000;
            hreadyout         <= 1'b0;
            hresp             <= 1'b0;
            counterRun        <= 1'b0;
            overflowIrqEnable <= 1'b0;
            moduleIrqEnable   <= CAF_MODIE_RST;
            intMask           <= CAF_IMASK_RST;
            overflowIrq       <= 1'b0;
            moduleIrq         <= 1'b0;
            irq               <= 1'b0;
        end
        else
        begin
            aph               <= next_aph;
            hrdata            <= next_hrdata;
            hreadyout         <= 1'b1;
            hresp             <= 1'b0;
            counterRun        <= next_counterRun;
            overflowIrqEnable <= next_overflowIrqEnable;
            moduleIrqEnable   <= next_moduleIrqEnable;
            intMask           <= next_intMask;
            overflowIrq       <= next_overflowIrq;
            moduleIrq         <= next_moduleIrq;
            irq               <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    ovf_sets_a: assert property (
        wrapPulse |=> counterOverflowFlag)
        else $error("Overflow flag not set after counter wrap.");

    ovf_request_a: assert property (
        (counterOverflowFlag && overflowIrqEnable) |=> overflowIrq)
        else $error("Enabled overflow flag raised no request.");

    ovf_hold_a: assert property (
        (counterOverflowFlag && !wrCtrl) |=> counterOverflowFlag)
        else $error("Overflow flag cleared without a software write.");

    run_hold_a: assert property (
        !counterRun |=> $stable(count))
        else $error("Counter moved while stopped.");

    run_step_a: assert property (
        (counterRun && countTick) |=> (count == $past(count) + 16'h0001))
        else $error("Running counter did not advance on its tick.");

    mod_sets_a: assert property (
        (moduleEvent != '0) |=> ((moduleEventFlag & $past(moduleEvent)) == $past(moduleEvent)))
        else $error("Module event did not set its flag.");

    mod_request_a: assert property (
        ((moduleEventFlag & moduleIrqEnable) != '0) |=> moduleIrq)
        else $error("Enabled module flag raised no request.");

    mod_hold_a: assert property (
        !wrCtrl |=> ((moduleEventFlag & $past(moduleEventFlag)) == $past(moduleEventFlag)))
        else $error("Module flag cleared without a software write.");

    ovf_mask_a: assert property (
        !overflowIrqEnable |=> !overflowIrq)
        else $error("Overflow request raised while disabled.");

    mod_mask_a: assert property (
        ((moduleEventFlag & moduleIrqEnable) == '0) |=> !moduleIrq)
        else $error("Module request raised with no enabled flag.");

    flag_load_a: assert property (
        (wrCtrl && !wrapPulse) |=> (counterOverflowFlag == $past(hwdata[CAF_OVF_BIT])))
        else $error("Write to overflow flag did not load the value.");

    mod_load_a: assert property (
        (wrCtrl && (moduleEvent == '0)) |=> (moduleEventFlag == $past(hwdata[CAF_MOD_N-1:0])))
        else $error("Write to module flags did not load the value.");

    mod_cause_a: assert property (
        (!wrCtrl && (moduleEvent == '0)) |=> $stable(moduleEventFlag))
        else $error("Module flag changed with no event or write.");

    ovf_cause_a: assert property (
        (!counterOverflowFlag && !wrapPulse && !wrCtrl) |=> !counterOverflowFlag)
        else $error("Overflow flag set without a counter wrap.");

    wrap_at_max_a: assert property (
        (counterRun && countTick && (&count)) |=> (wrapPulse && (count == '0)))
        else $error("Counter did not wrap from its maximum to zero.");

    run_load_a: assert property (
        wrCtrl |=> (counterRun == $past(hwdata[CAF_RUN_BIT])))
        else $error("Write did not load the run bit.");

    run_keep_a: assert property (
        !wrCtrl |=> $stable(counterRun))
        else $error("Run bit changed without a software write.");

    ovf_level_a: assert property (
        1'b1 |=> (overflowIrq == $past(counterOverflowFlag && overflowIrqEnable)))
        else $error("Overflow request is not flag and enable.");

    mod_level_a: assert property (
        1'b1 |=> (moduleIrq == $past((moduleEventFlag & moduleIrqEnable) != '0)))
        else $error("Module request is not flag and enable.");

    // ------------------------------------------------------------------
    // Interrupt status and bus checks
    // ------------------------------------------------------------------
    stat_sets_a: assert property (
        (eventSet != '0) |=> ((intStatus & $past(eventSet)) == $past(eventSet)))
        else $error("Event did not set its status bit.");

    stat_irq_a: assert property (
        1'b1 |=> (irq == $past((intStatus & intMask) != '0)))
        else $error("Interrupt output does not follow status and mask.");

    bus_okay_a: assert property (
        !$past(rst) |-> (hreadyout && !hresp))
        else $error("Bus slave stalled or answered with an error.");

    rdata_idle_a: assert property (
        (!aph.valid || aph.write) |-> (hrdata == 32'h0000_0000))
        else $error("Read data not zero outside a read data phase.");

endmodule : caf_control_flags

// [caf_tb.sv]
// Purpose: Self-checking bench of the counter array control and flag block.
// Assumes: Zero wait state AHB-Lite slave; request outputs lag by one cycle.
// Notes:   Overflow is reached with a full 16-bit count of ticks.
`timescale 1ns/1ps
module tb;
    import caf_pkg::*;

    // ------------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------------
    logic                 ref_clk     = 1'b0;
    logic                 rst         = 1'b1;
    logic                 hsel        = 1'b0;
    logic [31:0]          haddr       = 32'h0;
    logic [1:0]           htrans      = 2'h0;
    logic                 hwrite      = 1'b0;
    logic [2:0]           hsize       = 3'h2;
    logic [31:0]          hwdata      = 32'h0;
    logic                 hready;
    logic [31:0]          hrdata;
    logic                 hreadyout;
    logic                 hresp;
    logic                 countTick   = 1'b0;
    logic [CAF_MOD_N-1:0] moduleEvent = 6'h00;
    logic                 counterRun;
    logic                 overflowIrq;
    logic                 moduleIrq;
    logic                 irq;
    int                   num_errors  = 0;
    int                   checks_done = 0;

    assign hready = hreadyout;

    always #2 ref_clk = ~ref_clk;

    caf_control_flags dut (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .countTick(countTick), .moduleEvent(moduleEvent), .counterRun(counterRun),
        .overflowIrq(overflowIrq), .moduleIrq(moduleIrq), .irq(irq)
    );

    // ------------------------------------------------------------------
    // Compare, bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic check_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string nm, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %b seen %b", nm, exp, got);
        end
    endtask : check_bit

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        htrans <= CAF_HTRANS_NSEQ;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
        check_bit("hresp", 1'b0, hresp);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(a, 1'b1, d, v);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(a, 1'b0, 32'h0, v);
        check_word(nm, exp, v);
    endtask : rd_chk

    // Lets a written register reach the registered request outputs.
    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk) countTick <= 1'b1;
        @(posedge ref_clk) countTick <= 1'b0;
    endtask : ticks

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_values;
        rd_chk("ctrl", CAF_CTRL_OFF, 32'h0);
        rd_chk("mode", CAF_MODE_OFF, 32'h0);
        rd_chk("modie", CAF_MODIE_OFF, 32'h0);
        rd_chk("count", CAF_COUNT_OFF, 32'h0);
        rd_chk("istat", CAF_ISTAT_OFF, 32'h0);
        rd_chk("imask", CAF_IMASK_OFF, 32'h0);
        wr(8'h18, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h18, 32'h0);
        check_bit("irq", 1'b0, irq);
    endtask : test_reset_values

    task automatic test_counter_overflow;
        ticks(3);
        rd_chk("count stopped", CAF_COUNT_OFF, 32'h0);
        wr(CAF_CTRL_OFF, 32'h40);
        settle();
        check_bit("counterRun", 1'b1, counterRun);
        ticks(5);
        rd_chk("count running", CAF_COUNT_OFF, 32'h5);
        ticks(65531);
        repeat (3) @(posedge ref_clk);
        rd_chk("ctrl overflow", CAF_CTRL_OFF, 32'hC0);
        rd_chk("count wrapped", CAF_COUNT_OFF, 32'h0);
        rd_chk("istat overflow", CAF_ISTAT_OFF, 32'h40);
        check_bit("overflowIrq masked", 1'b0, overflowIrq);
        wr(CAF_MODE_OFF, 32'h1);
        wr(CAF_IMASK_OFF, 32'h40);
        settle();
        check_bit("overflowIrq", 1'b1, overflowIrq);
        check_bit("irq", 1'b1, irq);
        repeat (20) @(posedge ref_clk);
        rd_chk("ctrl sticky", CAF_CTRL_OFF, 32'hC0);
        wr(CAF_CTRL_OFF, 32'h0);
        rd_chk("ctrl cleared", CAF_CTRL_OFF, 32'h0);
        settle();
        check_bit("overflowIrq cleared", 1'b0, overflowIrq);
        check_bit("counterRun", 1'b0, counterRun);
        ticks(4);
        rd_chk("count held", CAF_COUNT_OFF, 32'h0);
        wr(CAF_ISTAT_OFF, 32'h40);
        settle();
        check_bit("irq cleared", 1'b0, irq);
        rd_chk("istat cleared", CAF_ISTAT_OFF, 32'h0);
        wr(CAF_MODE_OFF, 32'h0);
        wr(CAF_IMASK_OFF, 32'h0);
    endtask : test_counter_overflow

    task automatic test_module_flags;
        logic [5:0] m;
        for (int n = 0; n < CAF_MOD_N; n++)
        begin
            m = 6'h01 << n;
            @(posedge ref_clk) moduleEvent <= m;
            @(posedge ref_clk) moduleEvent <= 6'h00;
            rd_chk("module flag", CAF_CTRL_OFF, {26'h0, m});
            settle();
            check_bit("moduleIrq masked", 1'b0, moduleIrq);
            check_bit("irq masked", 1'b0, irq);
            wr(CAF_MODIE_OFF, {26'h0, m});
            wr(CAF_IMASK_OFF, {26'h0, m});
            settle();
            check_bit("moduleIrq", 1'b1, moduleIrq);
            check_bit("irq", 1'b1, irq);
            wr(CAF_MODIE_OFF, {26'h0, ~m});
            settle();
            check_bit("moduleIrq other", 1'b0, moduleIrq);
            repeat (10) @(posedge ref_clk);
            rd_chk("module sticky", CAF_CTRL_OFF, {26'h0, m});
            wr(CAF_CTRL_OFF, 32'h0);
            rd_chk("module cleared", CAF_CTRL_OFF, 32'h0);
            wr(CAF_ISTAT_OFF, {26'h0, m});
            settle();
            check_bit("irq cleared", 1'b0, irq);
            rd_chk("istat cleared", CAF_ISTAT_OFF, 32'h0);
            wr(CAF_IMASK_OFF, 32'h0);
            wr(CAF_MODIE_OFF, 32'h0);
        end
    endtask : test_module_flags

    task automatic test_sw_load;
        wr(CAF_CTRL_OFF, 32'hBF);
        rd_chk("ctrl loaded", CAF_CTRL_OFF, 32'hBF);
        wr(CAF_MODE_OFF, 32'h1);
        wr(CAF_MODIE_OFF, 32'h3F);
        settle();
        check_bit("overflowIrq forced", 1'b1, overflowIrq);
        check_bit("moduleIrq forced", 1'b1, moduleIrq);
        wr(CAF_CTRL_OFF, 32'h0);
        settle();
        check_bit("overflowIrq off", 1'b0, overflowIrq);
        check_bit("moduleIrq off", 1'b0, moduleIrq);
    endtask : test_sw_load

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (90000) @(posedge ref_clk);
        num_errors++;
        $display("Error watchdog expired");
        finish_test();
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        test_reset_values();
        test_counter_overflow();
        test_module_flags();
        test_sw_load();
        finish_test();
    end

endmodule : tb
